//--- src/tcst_ctrl.sv
// transceiver control and status sequencer with apb registers
//Contract
//- rising transmit-off darkens the laser within 100 us
//- in normal run, falling transmit-off relights the laser within 2 ms
//- management interface ready within 300 ms of power-on or plug
//- non-cooled part operational within 300 ms of any start event
//- cooled part operational within 90 s, also after high-power enable
//- non-cooled part at high power within 300 ms of the enabling write
//- back within base power within 300 ms of the disabling write
//- fault flag raised within 1 ms, or 50 ms when cooled
//- transmit-off held high at least 10 us resets a latched fault
//- rate change settles in 500 us for fibre channel, 24 ms otherwise
//- loss flag raised within 100 us of signal loss
//- loss flag cleared within 100 us of signal return
//- fault flag may be high while supplies come up
//- fault flag clears within start-up time when no fault exists
//- with transmit-off high at power-on, start-up counts from release
//- without safety circuitry the fault flag stays low
//- initialization starts only once transmit supply is good
//- a safety fault stays latched until reset pulse or soft toggle
//- low rate select picks 4.25 GBd or below, high picks above
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "tcst_params.svh"
module tcst_ctrl #(
   parameter logic [31:0] START_CYC = 32'(`TCST_CYC_MS(`TCST_START_MS)),
   parameter logic [31:0] START_COOLED_CYC = 32'(`TCST_CYC_S(`TCST_START_COOLED_S)),
   parameter logic [31:0] MGMT_CYC = 32'(`TCST_CYC_MS(`TCST_MGMT_MS)),
   parameter logic [31:0] T_ON_CYC = 32'(`TCST_CYC_MS(`TCST_T_ON_MS)),
   parameter logic [31:0] HP_UP_CYC = 32'(`TCST_CYC_MS(`TCST_HP_UP_MS)),
   parameter logic [31:0] HP_DOWN_CYC = 32'(`TCST_CYC_MS(`TCST_HP_DOWN_MS)),
   parameter logic [31:0] RATE_FC_CYC = 32'(`TCST_CYC_US(`TCST_RATE_FC_US)),
   parameter logic [31:0] RATE_CYC = 32'(`TCST_CYC_MS(`TCST_RATE_MS))
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic transmit_supply_ok,
   input wire logic transmit_off_input,
   input wire logic rx_rate_select,
   input wire logic tx_rate_select,
   input wire logic laser_fault_detect,
   input wire logic laser_power_good,
   input wire logic rx_signal_detect,
   input wire logic hp_power_good,
   input wire logic mgmt_init_done,
   output logic laser_enable,
   output logic transmit_fault_flag,
   output logic receive_signal_lost,
   output logic rx_rate_high,
   output logic tx_rate_high,
   output logic high_power_enable,
   output logic mgmt_ready,
   output logic tx_operational
);
   import tcst_pkg::*;

   typedef struct packed {
      tcst_state_t state;
      tcst_ctrl_t ctrl;
      logic soft_q;
      logic tx_off_q;
      logic [8:0] pulse_cnt;
      logic laser_en;
      logic fault_flag;
      logic los;
      logic rx_hi;
      logic tx_hi;
      logic hp_en;
      logic hp_busy;
      logic hp_late;
      logic rate_busy;
      logic mgmt_rdy;
      logic oper;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tcst_top_t;

   tcst_top_t r_reg;
   tcst_top_t r_next;

   logic [`TCST_NTM-1:0] t_rst;
   logic [`TCST_NTM-1:0] t_stop;
   logic [`TCST_NTM-1:0] t_done;
   logic [31:0] t_load [`TCST_NTM];
   logic dis_eff;
   logic reset_req;
   logic rate_chg;
   logic hp_chg;
   logic power_up;
   logic apb_done;
   logic [31:0] stat_word;

   // deadline timers, one per deadline: start, management, turn-on, power level, rate
   tcst_tmr_if tif[`TCST_NTM] ();
   for (genvar i = 0; i < `TCST_NTM; i++) begin : g_tm
      assign tif[i].restart = t_rst[i];
      assign tif[i].stop = t_stop[i];
      assign tif[i].load = t_load[i];
      assign t_done[i] = tif[i].done;
      tcst_timer u_tm (
         .pclk(pclk),
         .presetn(presetn),
         .t(tif[i])
      );
   end

   // event decode shared by the timers and the sequencer
   assign dis_eff = transmit_off_input || r_reg.ctrl.soft_dis;
   assign power_up = (r_reg.state == TCST_OFF) && transmit_supply_ok;
   assign reset_req = (r_reg.state == TCST_FAULT) &&
      ((r_reg.tx_off_q && !transmit_off_input &&
        r_reg.pulse_cnt >= `TCST_RESET_CYC) ||
       (r_reg.soft_q && !r_reg.ctrl.soft_dis));
   assign rate_chg = (rx_rate_select != r_reg.rx_hi) || (tx_rate_select != r_reg.tx_hi);
   assign hp_chg = r_reg.ctrl.hp_req != r_reg.hp_en;
   assign apb_done = psel && penable && !r_reg.pready;

   // restarts on every start event, all counted on pclk
   assign t_rst[`TCST_TM_START] = power_up || reset_req ||
      (r_reg.state == TCST_INIT && dis_eff);
   assign t_stop[`TCST_TM_START] = r_reg.state != TCST_INIT;
   assign t_load[`TCST_TM_START] = r_reg.ctrl.cooled ? START_COOLED_CYC : START_CYC;
   assign t_rst[`TCST_TM_MGMT] = power_up;
   assign t_stop[`TCST_TM_MGMT] = r_reg.mgmt_rdy;
   assign t_load[`TCST_TM_MGMT] = MGMT_CYC;
   // turn-on watchdog only in normal run, not start-up or recovery
   assign t_rst[`TCST_TM_ON] = (r_reg.state == TCST_RUN) && r_reg.tx_off_q &&
      !dis_eff && !laser_power_good;
   assign t_stop[`TCST_TM_ON] = laser_power_good || dis_eff || r_reg.state != TCST_RUN;
   assign t_load[`TCST_TM_ON] = T_ON_CYC;
   assign t_rst[`TCST_TM_HP] = hp_chg;
   assign t_stop[`TCST_TM_HP] = !r_reg.hp_busy;
   assign t_load[`TCST_TM_HP] = !r_reg.ctrl.hp_req ? HP_DOWN_CYC :
      (r_reg.ctrl.cooled ? START_COOLED_CYC : HP_UP_CYC);
   assign t_rst[`TCST_TM_RATE] = rate_chg;
   assign t_stop[`TCST_TM_RATE] = t_done[`TCST_TM_RATE];
   assign t_load[`TCST_TM_RATE] = r_reg.ctrl.fc ? RATE_FC_CYC : RATE_CYC;

   // status word: state, flags, busy bits
   assign stat_word = {22'h0, r_reg.los, r_reg.rate_busy, r_reg.hp_late, r_reg.hp_busy,
      r_reg.oper, r_reg.mgmt_rdy, r_reg.fault_flag, r_reg.laser_en, r_reg.state};

   // all next state in one place
   always_comb begin
      r_next = r_reg;
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
      // apb slave: one wait state, so pready is a flop
      if (apb_done) begin
         r_next.pready = 1'b1;
         r_next.prdata = 32'h0;
         case (paddr)
            `TCST_ADDR_CTRL: begin
               if (pwrite) begin
                  r_next.ctrl = pwdata[5:0];
               end else begin
                  r_next.prdata = {26'h0, r_reg.ctrl};
               end
            end
            `TCST_ADDR_STAT: begin
               if (pwrite) begin
                  if (pwdata[`TCST_S_HP_LATE]) begin
                     r_next.hp_late = 1'b0; // write one to clear
                  end
               end else begin
                  r_next.prdata = stat_word;
               end
            end
            default: begin
               r_next.pslverr = 1'b1;
            end
         endcase
      end
      r_next.soft_q = r_reg.ctrl.soft_dis;
      r_next.tx_off_q = transmit_off_input;
      // width of the transmit-off pulse, saturating
      if (!transmit_off_input) begin
         r_next.pulse_cnt = 9'h0;
      end else if (r_reg.pulse_cnt < `TCST_RESET_CYC) begin
         r_next.pulse_cnt = r_reg.pulse_cnt + 9'h1;
      end
      // sequencer
      case (r_reg.state)
         TCST_OFF: begin
            if (transmit_supply_ok) begin
               r_next.state = TCST_INIT;
            end
         end
         TCST_INIT: begin
            if (dis_eff) begin
               r_next.state = TCST_INIT;
            end else if (r_reg.ctrl.safety && laser_fault_detect) begin
               r_next.state = TCST_FAULT;
            end else if (laser_power_good) begin
               r_next.state = TCST_RUN;
            end else if (t_done[`TCST_TM_START]) begin
               r_next.state = TCST_FAULT;
            end
         end
         TCST_RUN: begin
            if (r_reg.ctrl.safety && (laser_fault_detect || t_done[`TCST_TM_ON])) begin
               r_next.state = TCST_FAULT;
            end
         end
         TCST_FAULT: begin
            if (reset_req) begin
               r_next.state = TCST_INIT;
            end
         end
         default: begin
            r_next.state = TCST_OFF;
         end
      endcase
      // supply loss forces the whole start-up again
      if (!transmit_supply_ok) begin
         r_next.state = TCST_OFF;
      end
      // laser follows transmit-off on the very next edge
      r_next.laser_en = (r_next.state == TCST_INIT || r_next.state == TCST_RUN) && !dis_eff;
      // high outside run while safety logic is fitted
      r_next.fault_flag = r_reg.ctrl.safety && (r_next.state != TCST_RUN);
      r_next.oper = r_next.state == TCST_RUN;
      r_next.los = r_reg.ctrl.los_en && !rx_signal_detect;
      r_next.rx_hi = rx_rate_select;
      r_next.tx_hi = tx_rate_select;
      r_next.rate_busy = rate_chg || (r_reg.rate_busy && !t_done[`TCST_TM_RATE]);
      // forced ready at the deadline even if init never reports done
      r_next.mgmt_rdy = (r_reg.state != TCST_OFF) && (r_reg.mgmt_rdy ||
         mgmt_init_done || t_done[`TCST_TM_MGMT]);
      r_next.hp_en = r_reg.ctrl.hp_req;
      if (hp_chg) begin
         r_next.hp_busy = 1'b1;
      end else if (hp_power_good == r_reg.hp_en) begin
         r_next.hp_busy = 1'b0;
      end
      // late power change: set wins over the clear
      if (r_reg.hp_busy && t_done[`TCST_TM_HP]) begin
         r_next.hp_late = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
         r_reg.ctrl <= `TCST_CTRL_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // every output straight from the state register
   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign laser_enable = r_reg.laser_en;
   assign transmit_fault_flag = r_reg.fault_flag;
   assign receive_signal_lost = r_reg.los;
   assign rx_rate_high = r_reg.rx_hi;
   assign tx_rate_high = r_reg.tx_hi;
   assign high_power_enable = r_reg.hp_en;
   assign mgmt_ready = r_reg.mgmt_rdy;
   assign tx_operational = r_reg.oper;

   // checks
   localparam int LAT = 1;

   AST_TX_OFF_DARK: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(transmit_off_input) |-> ##[1:LAT] !laser_enable)
      else $error("laser still on after transmit-off rose");
   AST_TX_ON_RUN: assert property (@(posedge pclk) disable iff (!presetn)
      r_reg.state == TCST_RUN && !dis_eff && !laser_fault_detect && !t_done[`TCST_TM_ON]
      && transmit_supply_ok |=> laser_enable)
      else $error("laser not lit in run with transmit-off low");
   AST_MGMT_READY: assert property (@(posedge pclk) disable iff (!presetn)
      t_done[`TCST_TM_MGMT] && r_reg.state != TCST_OFF |=> mgmt_ready)
      else $error("management not ready at its deadline");
   AST_START_DEADLINE: assert property (@(posedge pclk) disable iff (!presetn)
      r_reg.state == TCST_INIT && t_done[`TCST_TM_START] && !dis_eff && !laser_power_good
      && transmit_supply_ok && r_reg.ctrl.safety
      |=> r_reg.state == TCST_FAULT && transmit_fault_flag)
      else $error("start-up deadline passed without fault");
   AST_FAULT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
      r_reg.state == TCST_RUN && r_reg.ctrl.safety && laser_fault_detect && transmit_supply_ok
      |=> transmit_fault_flag ##1 transmit_fault_flag)
      else $error("fault not flagged");
   AST_RESET_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      r_reg.state == TCST_FAULT && reset_req && transmit_supply_ok
      |=> r_reg.state == TCST_INIT)
      else $error("reset pulse did not restart");
   AST_RATE_SEL: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 rx_rate_high == $past(rx_rate_select) && tx_rate_high == $past(tx_rate_select))
      else $error("rate select not applied");
   AST_LOS_ON: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(rx_signal_detect) && r_reg.ctrl.los_en |=> receive_signal_lost)
      else $error("loss not flagged");
   AST_LOS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(rx_signal_detect) |=> !receive_signal_lost)
      else $error("loss flag not cleared");
   AST_CLEAR_RUN: assert property (@(posedge pclk) disable iff (!presetn)
      r_reg.state == TCST_INIT && !dis_eff && laser_power_good && !laser_fault_detect
      && transmit_supply_ok |=> !transmit_fault_flag && tx_operational)
      else $error("fault flag not cleared on good start");
   AST_NO_SAFETY: assert property (@(posedge pclk) disable iff (!presetn)
      !r_reg.ctrl.safety [*2] |-> !transmit_fault_flag)
      else $error("fault flag high without safety logic");
   AST_FAULT_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
      r_reg.state == TCST_FAULT && !reset_req && transmit_supply_ok
      |=> r_reg.state == TCST_FAULT && !laser_enable)
      else $error("fault latch released without reset");
   AST_SUPPLY: assert property (@(posedge pclk) disable iff (!presetn)
      !transmit_supply_ok |=> r_reg.state == TCST_OFF && !laser_enable)
      else $error("running without transmit supply");
   // a select change always opens a settle window
   AST_RATE_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
      rate_chg |=> r_reg.rate_busy && rx_rate_high == $past(rx_rate_select))
      else $error("rate change not marked busy");
   AST_HP_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
      hp_chg |=> r_reg.hp_busy && high_power_enable == $past(r_reg.ctrl.hp_req))
      else $error("power level change not applied");
   // a pulse shorter than the reset width must leave the latch alone
   AST_SHORT_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      r_reg.state == TCST_FAULT && r_reg.pulse_cnt < `TCST_RESET_CYC && !r_reg.soft_q
      && transmit_supply_ok |=> r_reg.state == TCST_FAULT)
      else $error("short transmit-off pulse cleared the fault");

   COV_START: cover property (@(posedge pclk) disable iff (!presetn)
      r_reg.state == TCST_INIT ##1 r_reg.state == TCST_RUN);
   COV_RECOVER: cover property (@(posedge pclk) disable iff (!presetn)
      r_reg.state == TCST_FAULT ##1 r_reg.state == TCST_INIT);
   COV_HP_LATE: cover property (@(posedge pclk) disable iff (!presetn) $rose(r_reg.hp_late));
   COV_RATE: cover property (@(posedge pclk) disable iff (!presetn) $fell(r_reg.rate_busy));
   COV_MGMT: cover property (@(posedge pclk) disable iff (!presetn) $rose(mgmt_ready));
endmodule : tcst_ctrl

//--- src/tcst_params.svh
// constants of the transceiver control and status sequencer
`ifndef TCST_PARAMS_SVH
`define TCST_PARAMS_SVH
`define TCST_CLK_HZ 64'd40000000
// longest times round down, least times round up
`define TCST_CYC_US(t) (((t) * `TCST_CLK_HZ) / 64'd1000000)
`define TCST_CYC_MS(t) (((t) * `TCST_CLK_HZ) / 64'd1000)
`define TCST_CYC_S(t) ((t) * `TCST_CLK_HZ)
`define TCST_CYC_US_UP(t) (((t) * `TCST_CLK_HZ + 64'd999999) / 64'd1000000)
`define TCST_T_ON_MS 64'd2
`define TCST_MGMT_MS 64'd300
`define TCST_START_MS 64'd300
`define TCST_START_COOLED_S 64'd90
`define TCST_HP_UP_MS 64'd300
`define TCST_HP_DOWN_MS 64'd300
`define TCST_RESET_US 64'd10
`define TCST_RATE_FC_US 64'd500
`define TCST_RATE_MS 64'd24
`define TCST_RESET_CYC 9'(`TCST_CYC_US_UP(`TCST_RESET_US))
// timer slots
`define TCST_NTM 5
`define TCST_TM_START 0
`define TCST_TM_MGMT 1
`define TCST_TM_ON 2
`define TCST_TM_HP 3
`define TCST_TM_RATE 4
// register map
`define TCST_ADDR_CTRL 8'h00
`define TCST_ADDR_STAT 8'h04
`define TCST_CTRL_RST 6'h30
`define TCST_S_HP_LATE 7
`endif

//--- src/tcst_pkg.sv
// types of the transceiver control and status sequencer
package tcst_pkg;
   typedef enum logic [1:0] {
      TCST_OFF = 2'b00,
      TCST_INIT = 2'b01,
      TCST_RUN = 2'b10,
      TCST_FAULT = 2'b11
   } tcst_state_t;
   // control word, msb first: los_en safety soft_dis hp_req fc cooled
   typedef struct packed {
      logic los_en;
      logic safety;
      logic soft_dis;
      logic hp_req;
      logic fc;
      logic cooled;
   } tcst_ctrl_t;
   typedef struct packed {
      logic armed;
      logic [31:0] cnt;
   } tcst_tmr_t;
endpackage : tcst_pkg

//--- src/tcst_tmr_if.sv
// carrier between the sequencer and one deadline timer
`timescale 1ns/1ps
interface tcst_tmr_if;
   logic restart;
   logic stop;
   logic [31:0] load;
   logic done;
   modport ctl (output restart, output stop, output load, input done);
   modport tmr (input restart, input stop, input load, output done);
endinterface : tcst_tmr_if

//--- src/tcst_timer.sv
// one-shot down-counting deadline timer
`timescale 1ns/1ps
module tcst_timer (
   input wire logic pclk,
   input wire logic presetn,
   tcst_tmr_if.tmr t
);
   import tcst_pkg::*;
   tcst_tmr_t s_reg;
   tcst_tmr_t s_next;

   // restart wins over stop so a fresh deadline is never lost
   always_comb begin
      s_next = s_reg;
      if (t.restart) begin
         s_next.armed = 1'b1;
         s_next.cnt = t.load;
      end else if (t.stop) begin
         s_next.armed = 1'b0;
      end else if (s_reg.armed && s_reg.cnt != 32'h0) begin
         s_next.cnt = s_reg.cnt - 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // level until stopped or restarted
   assign t.done = s_reg.armed && (s_reg.cnt == 32'h0);
endmodule : tcst_timer

//--- tb/tcst_host.sv
// host-side model that drives transmit-off and watches the fault line
`timescale 1ns/1ps
module tcst_host #(
   parameter int START_CYC = 200,
   parameter int START_COOLED_CYC = 400
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic present,
   input wire logic cooled,
   input wire logic off_req,
   input wire logic pulse_go,
   input wire logic [9:0] pulse_len,
   input wire logic fault_pin,
   output logic transmit_off_input,
   output logic fault_line,
   output logic fault_declared
);
   logic [9:0] pulse_cnt;
   int high_cnt;
   // an empty slot reads as a fault through the host pull-up
   assign fault_line = present ? fault_pin : 1'h1;
   // pulse length comes from the caller, 400 cycles is the legal minimum
   assign transmit_off_input = off_req | (pulse_cnt != 10'h0);
   // cooled parts get the longer grace before a fault is declared
   assign fault_declared = high_cnt > (cooled ? START_COOLED_CYC : START_CYC);
   // pulse counter and fault-high duration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt <= 10'h0;
         high_cnt <= 0;
      end else begin
         if (pulse_go) begin
            pulse_cnt <= pulse_len;
         end else if (pulse_cnt != 10'h0) begin
            pulse_cnt <= pulse_cnt - 10'h1;
         end
         high_cnt <= (present && fault_line) ? high_cnt + 1 : 0;
      end
   end
endmodule : tcst_host

//--- tb/tcst_ctrl_tb.sv
// self-checking bench of the transceiver control and status sequencer
`timescale 1ns/1ps
`include "tcst_params.svh"
module tcst_ctrl_tb;
   import tcst_pkg::*;
   localparam int RATE_FC = 20;
   localparam int RATE = 60;
   localparam int HP = 100;
   localparam int START = 200;
   localparam int MGMT = 100;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic err, supply_ok = 1'h0, rx_sel = 1'h0, tx_sel = 1'h0, lfd = 1'h0, lpg = 1'h0;
   logic lpg_ok = 1'h0, rx_sd = 1'h1, hp_good = 1'h0, present = 1'h0, off_req = 1'h0;
   logic pulse_go = 1'h0, mgmt_done = 1'h0, h_cooled = 1'h0;
   logic [9:0] pulse_len = 10'h0;
   logic pready, pslverr, tx_off, laser_en, fault, los, rx_hi, tx_hi, hpe, mready, oper;
   logic fault_line, fault_decl;
   int num_errors = 0, checked = 0, cyc = 0, i;
   always #12.5 pclk = ~pclk;
   // laser output follows its enable one cycle later while healthy
   always_ff @(posedge pclk) lpg <= laser_en & lpg_ok;
   // timers the bench never lets run out keep their real lengths
   tcst_ctrl #(.START_CYC(START), .MGMT_CYC(MGMT), .HP_DOWN_CYC(HP), .RATE_FC_CYC(RATE_FC),
      .RATE_CYC(RATE)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .transmit_supply_ok(supply_ok),
      .transmit_off_input(tx_off), .rx_rate_select(rx_sel), .tx_rate_select(tx_sel),
      .laser_fault_detect(lfd), .laser_power_good(lpg), .rx_signal_detect(rx_sd),
      .hp_power_good(hp_good), .mgmt_init_done(mgmt_done), .laser_enable(laser_en),
      .transmit_fault_flag(fault), .receive_signal_lost(los), .rx_rate_high(rx_hi),
      .tx_rate_high(tx_hi), .high_power_enable(hpe), .mgmt_ready(mready),
      .tx_operational(oper));
   tcst_host u_host (.pclk(pclk), .presetn(presetn), .present(present), .cooled(h_cooled),
      .off_req(off_req), .pulse_go(pulse_go), .pulse_len(pulse_len), .fault_pin(fault),
      .transmit_off_input(tx_off), .fault_line(fault_line), .fault_declared(fault_decl));
   task automatic finish_test();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test
   // hang guard, tests need well under 5000 cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, held until pready is seen at an edge; only the hang guard ends a wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   // run a host reset pulse of the given length, then wait len plus 5 cycles
   task automatic pulse(input logic [9:0] len);
      pulse_len <= len;
      pulse_go <= 1'h1;
      @(posedge pclk);
      pulse_go <= 1'h0;
      repeat (len + 10'h5) @(posedge pclk);
   endtask : pulse
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, `TCST_ADDR_CTRL, 32'h0);
      chk(rd, {26'h0, `TCST_CTRL_RST});
      apb(1'h1, 8'h08, 32'hffffffff);
      chk(err, 1'h1);
      apb(1'h0, 8'h08, 32'h0);
      chk(err, 1'h1);
      chk(rd, 32'h0);
      apb(1'h0, `TCST_ADDR_STAT, 32'h0);
      chk({rd[5], rd[2:0]}, 4'h0);
      chk(fault_line, 1'h1);
      $display("test reset done");
      present <= 1'h1;
      supply_ok <= 1'h1;
      repeat (3) @(posedge pclk);
      chk({fault, laser_en, oper}, 3'h6);
      lpg_ok <= 1'h1;
      for (i = 0; i < 12 && oper !== 1'h1; i++) @(posedge pclk);
      chk({fault, oper}, 2'h1);
      for (i = 0; i < 110 && mready !== 1'h1; i++) @(posedge pclk);
      chk(mready, 1'h1);
      $display("test start done");
      off_req <= 1'h1;
      repeat (2) @(posedge pclk);
      chk(laser_en, 1'h0);
      off_req <= 1'h0;
      repeat (2) @(posedge pclk);
      chk(laser_en, 1'h1);
      repeat (60) @(posedge pclk);
      chk({fault, oper}, 2'h1);
      rx_sd <= 1'h0;
      repeat (2) @(posedge pclk);
      chk(los, 1'h1);
      rx_sd <= 1'h1;
      repeat (2) @(posedge pclk);
      chk(los, 1'h0);
      $display("test pins done");
      for (int fc = 0; fc < 2; fc++) begin
         apb(1'h1, `TCST_ADDR_CTRL, fc ? 32'h32 : 32'h30);
         rx_sel <= ~rx_sel;
         tx_sel <= ~tx_sel;
         repeat (2) @(posedge pclk);
         chk({rx_hi, tx_hi}, {rx_sel, tx_sel});
         apb(1'h0, `TCST_ADDR_STAT, 32'h0);
         chk(rd[8], 1'h1);
         repeat (fc ? RATE_FC : RATE) @(posedge pclk);
         apb(1'h0, `TCST_ADDR_STAT, 32'h0);
         chk(rd[8], 1'h0);
      end
      $display("test rate done");
      apb(1'h1, `TCST_ADDR_CTRL, 32'h34);
      chk(hpe, 1'h1);
      apb(1'h0, `TCST_ADDR_STAT, 32'h0);
      chk(rd[7:6], 2'h1);
      hp_good <= 1'h1;
      repeat (3) @(posedge pclk);
      apb(1'h0, `TCST_ADDR_STAT, 32'h0);
      chk(rd[7:6], 2'h0);
      apb(1'h1, `TCST_ADDR_CTRL, 32'h30);
      repeat (HP + 10) @(posedge pclk);
      apb(1'h0, `TCST_ADDR_STAT, 32'h0);
      chk({hpe, rd[7:6]}, 3'h3);
      // clear while still late: the set wins
      apb(1'h1, `TCST_ADDR_STAT, 32'h80);
      apb(1'h0, `TCST_ADDR_STAT, 32'h0);
      chk(rd[7], 1'h1);
      hp_good <= 1'h0;
      apb(1'h1, `TCST_ADDR_STAT, 32'h80);
      apb(1'h0, `TCST_ADDR_STAT, 32'h0);
      chk(rd[7:6], 2'h0);
      $display("test power level done");
      lfd <= 1'h1;
      repeat (3) @(posedge pclk);
      chk({fault, oper}, 2'h2);
      lfd <= 1'h0;
      pulse(10'h64);
      repeat (120) @(posedge pclk);
      chk({fault, fault_decl}, 2'h3);
      // a cooled part gets the longer grace
      h_cooled <= 1'h1;
      @(posedge pclk);
      chk(fault_decl, 1'h0);
      h_cooled <= 1'h0;
      pulse(10'h190);
      for (i = 0; i < 210 && oper !== 1'h1; i++) @(posedge pclk);
      chk({fault, oper}, 2'h1);
      lfd <= 1'h1;
      repeat (3) @(posedge pclk);
      lfd <= 1'h0;
      apb(1'h1, `TCST_ADDR_CTRL, 32'h38);
      apb(1'h1, `TCST_ADDR_CTRL, 32'h30);
      for (i = 0; i < 210 && oper !== 1'h1; i++) @(posedge pclk);
      chk({fault, oper}, 2'h1);
      apb(1'h1, `TCST_ADDR_CTRL, 32'h20);
      lfd <= 1'h1;
      repeat (5) @(posedge pclk);
      chk(fault, 1'h0);
      lfd <= 1'h0;
      $display("test fault done");
      supply_ok <= 1'h0;
      repeat (3) @(posedge pclk);
      chk({mready, oper, laser_en}, 3'h0);
      mgmt_done <= 1'h1;
      supply_ok <= 1'h1;
      repeat (3) @(posedge pclk);
      chk({mready, fault}, 2'h2);
      $display("test supply done");
      finish_test();
   end
endmodule : tcst_ctrl_tb
